// ---- rtl/phase_counter.sv ----
// Four-phase instruction cycle generator, one phase per clock.
// Assumes the core clock is the only clock; phases restart at Q1 on reset.
`include "return_ops_regs.svh"

module phase_counter (
    input wire logic clk,
    input wire logic nrst,
    output return_ops_pkg::phase_t phase
);

    return_ops_pkg::phase_t phase_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= return_ops_pkg::PH_Q1;
        end else begin
            unique case (phase_reg)
                return_ops_pkg::PH_Q1: phase_reg <= return_ops_pkg::PH_Q2;
                return_ops_pkg::PH_Q2: phase_reg <= return_ops_pkg::PH_Q3;
                return_ops_pkg::PH_Q3: phase_reg <= return_ops_pkg::PH_Q4;
                return_ops_pkg::PH_Q4: phase_reg <= return_ops_pkg::PH_Q1;
            endcase
        end
    end

    assign phase = phase_reg;

endmodule

// ---- rtl/return_ops_pkg.sv ----
// Types shared by the return execution block and its phase generator.
// Assumes the constants header is on the include path.
`include "return_ops_regs.svh"

package return_ops_pkg;

    typedef enum logic [1:0] {
        PH_Q1 = `PH_Q1,
        PH_Q2 = `PH_Q2,
        PH_Q3 = `PH_Q3,
        PH_Q4 = `PH_Q4
    } phase_t;

    typedef enum logic [1:0] {
        ST_IDLE = `ST_IDLE,
        ST_FIRST = `ST_FIRST,
        ST_SECOND = `ST_SECOND
    } state_t;

    typedef enum logic [1:0] {
        OP_NONE = `OP_NONE,
        OP_LIT = `OP_LIT,
        OP_RET = `OP_RET,
        OP_IRET = `OP_IRET
    } op_t;

    // Effects handed to the core's datapath
    typedef struct packed {
        logic w_we;
        logic [`LIT_W-1:0] w_data;
        logic stack_pop;
        logic pc_load;
        logic [`PC_W-1:0] pc_value;
        logic [`CTRL_W-1:0] ctrl_set;
    } retire_t;

endpackage

// ---- rtl/return_ops_regs.svh ----
// Constants for the subroutine-return execution block.
// Assumes a 14-bit instruction word and a 13-bit program counter.
`ifndef RETURN_OPS_REGS_SVH
`define RETURN_OPS_REGS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define INSTR_W 14
`define PC_W 13
`define LIT_W 8
`define CTRL_W 8

// ----------------------------------------
// Encodings
// ----------------------------------------
`define LIT_RET_TOP 4'hd
`define PLAIN_RET_CODE 14'h0008
`define IRQ_RET_CODE 14'h0009
`define IRQ_ENABLE_BIT 7
`define IRQ_ENABLE_MASK 8'h80

// ----------------------------------------
// Phase, state and operation codes
// ----------------------------------------
`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3
`define ST_IDLE 2'h0
`define ST_FIRST 2'h1
`define ST_SECOND 2'h2
`define OP_NONE 2'h0
`define OP_LIT 2'h1
`define OP_RET 2'h2
`define OP_IRET 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LIT_RST 8'h00
`define PC_RST 13'h0000
`define CTRL_RST 8'h00

`endif

// ---- rtl/subroutine_return_ops.sv ----
// Execution of the subroutine-return instructions of the core.
// Assumes the fetch stage presents each instruction word at Q1 and the
// hardware stack shows its top entry on stack_top at all times.
`include "return_ops_regs.svh"

// What this block does
// - Literal return writes literal to W, flags untouched
// - Literal return pops stack into PC at Q4
// - Literal return takes two instruction cycles
// - Plain return pops stack into PC at Q4
// - Plain return takes two instruction cycles
// - Interrupt return pops and sets global enable
module subroutine_return_ops (
    input wire logic clk,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire logic [`INSTR_W-1:0] instr,
    input wire logic [`PC_W-1:0] stack_top,
    output return_ops_pkg::retire_t retire,
    output logic busy,
    output logic flush,
    output return_ops_pkg::phase_t phase
);

    return_ops_pkg::phase_t ph;
    return_ops_pkg::state_t state_reg;
    return_ops_pkg::op_t op_reg;
    return_ops_pkg::op_t op_next;
    logic [`LIT_W-1:0] lit_reg;
    return_ops_pkg::retire_t retire_reg;
    logic busy_reg;
    logic flush_reg;
    return_ops_pkg::phase_t phase_reg;
    logic first_q2;
    logic first_q3;
    logic take;

    phase_counter phase_counter_inst (
        .clk(clk),
        .nrst(nrst),
        .phase(ph)
    );

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    always_comb begin
        op_next = return_ops_pkg::OP_NONE;
        if (instr[`INSTR_W-1:`INSTR_W-4] == `LIT_RET_TOP) begin
            op_next = return_ops_pkg::OP_LIT;
        end else if (instr == `PLAIN_RET_CODE) begin
            op_next = return_ops_pkg::OP_RET;
        end else if (instr == `IRQ_RET_CODE) begin
            op_next = return_ops_pkg::OP_IRET;
        end
    end

    // Other opcodes belong to the rest of the core and are ignored here
    assign take = instr_valid && (ph == return_ops_pkg::PH_Q1)
        && (state_reg == return_ops_pkg::ST_IDLE)
        && (op_next != return_ops_pkg::OP_NONE);
    assign first_q2 = (state_reg == return_ops_pkg::ST_FIRST) && (ph == return_ops_pkg::PH_Q2);
    assign first_q3 = (state_reg == return_ops_pkg::ST_FIRST) && (ph == return_ops_pkg::PH_Q3);

    // ----------------------------------------
    // Instruction cycle sequencing
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= return_ops_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                return_ops_pkg::ST_IDLE: begin
                    if (take) begin
                        state_reg <= return_ops_pkg::ST_FIRST;
                    end
                end
                return_ops_pkg::ST_FIRST: begin
                    if (ph == return_ops_pkg::PH_Q4) begin
                        state_reg <= return_ops_pkg::ST_SECOND;
                    end
                end
                return_ops_pkg::ST_SECOND: begin
                    if (ph == return_ops_pkg::PH_Q4) begin
                        state_reg <= return_ops_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= return_ops_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Literal is caught at decode so a new fetch cannot disturb it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            op_reg <= return_ops_pkg::OP_NONE;
            lit_reg <= `LIT_RST;
        end else if (take) begin
            op_reg <= op_next;
            lit_reg <= instr[`LIT_W-1:0];
        end
    end

    // ----------------------------------------
    // Datapath effects, registered one phase ahead
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            retire_reg.w_we <= 1'b0;
            retire_reg.w_data <= `LIT_RST;
            retire_reg.stack_pop <= 1'b0;
            retire_reg.pc_load <= 1'b0;
            retire_reg.pc_value <= `PC_RST;
            retire_reg.ctrl_set <= `CTRL_RST;
        end else begin
            retire_reg.w_we <= first_q3 && (op_reg == return_ops_pkg::OP_LIT);
            retire_reg.stack_pop <= first_q3;
            retire_reg.pc_load <= first_q3;
            if (first_q3) begin
                retire_reg.w_data <= lit_reg;
                retire_reg.pc_value <= stack_top;
            end
            // Global enable goes out in Q3 of the first cycle
            if (first_q2 && (op_reg == return_ops_pkg::OP_IRET)) begin
                retire_reg.ctrl_set <= `IRQ_ENABLE_MASK;
            end else begin
                retire_reg.ctrl_set <= `CTRL_RST;
            end
        end
    end

    // Flush covers the whole second cycle so the stale prefetch never runs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flush_reg <= 1'b0;
            busy_reg <= 1'b0;
            phase_reg <= return_ops_pkg::PH_Q1;
        end else begin
            phase_reg <= ph;
            if (take) begin
                busy_reg <= 1'b1;
            end else if ((state_reg == return_ops_pkg::ST_SECOND)
                && (ph == return_ops_pkg::PH_Q4)) begin
                busy_reg <= 1'b0;
            end
            if ((state_reg == return_ops_pkg::ST_FIRST) && (ph == return_ops_pkg::PH_Q4)) begin
                flush_reg <= 1'b1;
            end else if ((state_reg == return_ops_pkg::ST_SECOND)
                && (ph == return_ops_pkg::PH_Q4)) begin
                flush_reg <= 1'b0;
            end
        end
    end

    assign retire = retire_reg;
    assign busy = busy_reg;
    assign flush = flush_reg;
    assign phase = phase_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence first_cycle;
        (state_reg == return_ops_pkg::ST_FIRST) [*3];
    endsequence

    sequence second_cycle;
        (state_reg == return_ops_pkg::ST_SECOND) [*4];
    endsequence

    sequence flush_window;
        flush_reg [*4];
    endsequence

    a_lit_write: assert property (@(posedge clk) disable iff (!nrst)
        first_q3 && (op_reg == return_ops_pkg::OP_LIT)
        |=> retire_reg.w_we && (retire_reg.w_data == $past(lit_reg)))
        else $error("literal not written to W");

    a_w_only_lit: assert property (@(posedge clk) disable iff (!nrst)
        retire_reg.w_we |-> (op_reg == return_ops_pkg::OP_LIT) && retire_reg.stack_pop)
        else $error("W written outside literal return");

    a_pop_phase: assert property (@(posedge clk) disable iff (!nrst)
        retire_reg.stack_pop |-> (ph == return_ops_pkg::PH_Q4)
        && (state_reg == return_ops_pkg::ST_FIRST) && retire_reg.pc_load)
        else $error("pop outside Q4 of first cycle");

    a_pc_from_top: assert property (@(posedge clk) disable iff (!nrst)
        retire_reg.pc_load |-> retire_reg.pc_value == $past(stack_top))
        else $error("PC not loaded from stack top");

    a_two_cycles: assert property (@(posedge clk) disable iff (!nrst)
        take |=> first_cycle ##1 second_cycle ##1 (state_reg == return_ops_pkg::ST_IDLE))
        else $error("return did not take two cycles");

    a_busy_span: assert property (@(posedge clk) disable iff (!nrst)
        take |=> busy_reg [*7] ##1 !busy_reg)
        else $error("busy span wrong");

    a_irq_enable: assert property (@(posedge clk) disable iff (!nrst)
        first_q2 && (op_reg == return_ops_pkg::OP_IRET)
        |=> (retire_reg.ctrl_set == `IRQ_ENABLE_MASK) ##1 retire_reg.stack_pop)
        else $error("global enable not set on interrupt return");

    a_second_nop: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == return_ops_pkg::ST_SECOND) |-> flush_reg && !retire_reg.w_we
        && !retire_reg.stack_pop && (retire_reg.ctrl_set == `CTRL_RST))
        else $error("activity in second cycle");

    a_flush_span: assert property (@(posedge clk) disable iff (!nrst)
        retire_reg.stack_pop |=> flush_window ##1 !flush_reg)
        else $error("flush span wrong");

    a_set_only_iret: assert property (@(posedge clk) disable iff (!nrst)
        (retire_reg.ctrl_set != `CTRL_RST) |-> (op_reg == return_ops_pkg::OP_IRET)
        && (state_reg == return_ops_pkg::ST_FIRST) && (ph == return_ops_pkg::PH_Q3))
        else $error("global enable set outside interrupt return");

    // Captured values must not drift while the stack moves on
    a_hold_values: assert property (@(posedge clk) disable iff (!nrst)
        !$past(first_q3) |-> $stable(retire_reg.pc_value) && $stable(retire_reg.w_data))
        else $error("captured values moved");

endmodule

// ---- test/test_subroutine_return_ops.sv ----
// Self-checking bench for the subroutine-return execution block.
// Assumes the design files and the constants header are compiled first.
`include "return_ops_regs.svh"

module test_subroutine_return_ops;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals and instance
    // ----------------------------------------
    logic clk;
    logic nrst;
    logic instr_valid;
    logic [`INSTR_W-1:0] instr;
    logic [`PC_W-1:0] stack_top;
    return_ops_pkg::retire_t retire;
    logic busy;
    logic flush;
    return_ops_pkg::phase_t phase;
    int n_mismatch = 0;
    int cmp_count = 0;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    subroutine_return_ops subroutine_return_ops_inst (
        .clk(clk),
        .nrst(nrst),
        .instr_valid(instr_valid),
        .instr(instr),
        .stack_top(stack_top),
        .retire(retire),
        .busy(busy),
        .flush(flush),
        .phase(phase)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic stop_test;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Output phase lags by one clock: Q3 seen now means the take edge is two edges on
    task automatic issue(input logic [13:0] code, input logic valid, input logic [12:0] top);
        int i;
        i = 0;
        @(negedge clk);
        while (phase !== return_ops_pkg::PH_Q3) begin
            i++;
            if (i > 8) begin
                n_mismatch++;
                stop_test();
            end
            @(negedge clk);
        end
        @(posedge clk);
        instr_valid <= valid;
        instr <= code;
        stack_top <= top;
        @(posedge clk);
        instr_valid <= 1'b0;
        instr <= ~code;
    endtask

    task automatic idle_check;
        check("idle outputs",
            {busy, flush, retire.w_we, retire.stack_pop, retire.pc_load, phase}, 16'h0000);
        check("idle ctrl_set", retire.ctrl_set, 16'h0000);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Kind 1 literal, 2 plain, 3 interrupt, 0 refused; junk offers a return while busy
    task automatic run_op(input logic [13:0] code, input logic valid, input int kind,
        input logic junk, input logic [12:0] top);
        logic act;
        act = valid && kind != 0;
        issue(code, valid, top);
        for (int n = 1; n <= 8; n++) begin
            @(posedge clk);
            if (junk && n == 1) begin
                instr_valid <= 1'b1;
                instr <= `PLAIN_RET_CODE;
            end
            if (n == 7)
                instr_valid <= 1'b0;
            // Stack moves on after capture; pc_value must not follow
            if (n == 4)
                stack_top <= ~top;
            @(negedge clk);
            // Sampled after edge n, so the value shown is that of cycle n+1
            check("busy", busy, act && n <= 6);
            check("flush", flush, act && n >= 3 && n <= 6);
            check("pc_load", retire.pc_load, act && n == 2);
            check("stack_pop", retire.stack_pop, act && n == 2);
            check("w_we", retire.w_we, act && kind == 1 && n == 2);
            check("ctrl_set", retire.ctrl_set,
                (act && kind == 3 && n == 1) ? 16'h0080 : 16'h0000);
            check("phase", phase, 16'(n % 4));
            if (act && n >= 2)
                check("pc_value", retire.pc_value, top);
            if (act && kind == 1 && n >= 2)
                check("w_data", retire.w_data, code[7:0]);
        end
    endtask

    task automatic reset_mid_run;
        issue(14'h34a5, 1'b1, 13'h0f0f);
        @(posedge clk);
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        idle_check();
        @(posedge clk);
        nrst <= 1'b1;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        instr_valid = 1'b0;
        instr = 14'h0000;
        stack_top = 13'h0000;
        repeat (4) @(posedge clk);
        @(negedge clk);
        idle_check();
        @(posedge clk);
        nrst <= 1'b1;
        run_op(14'h34a5, 1'b1, 1, 1'b0, 13'h1abc);
        // Bits 9:8 set, literal at its top value
        run_op(14'h37ff, 1'b1, 1, 1'b1, 13'h0001);
        run_op(14'h3400, 1'b1, 1, 1'b0, 13'h1fff);
        run_op(`PLAIN_RET_CODE, 1'b1, 2, 1'b1, 13'h0123);
        run_op(`IRQ_RET_CODE, 1'b1, 3, 1'b0, 13'h1555);
        run_op(`PLAIN_RET_CODE, 1'b0, 2, 1'b0, 13'h0aaa);
        run_op(14'h3000, 1'b1, 0, 1'b0, 13'h0333);
        run_op(14'h3800, 1'b1, 0, 1'b0, 13'h0444);
        run_op(14'h0000, 1'b1, 0, 1'b0, 13'h0555);
        run_op(14'h000a, 1'b1, 0, 1'b0, 13'h0666);
        reset_mid_run();
        run_op(`PLAIN_RET_CODE, 1'b1, 2, 1'b0, 13'h1246);
        stop_test();
    end
endmodule
